// >>> mbo_barrier.sv
// Barrier controller between the issue stage and the load/store datapath.
// Older accesses are tracked by two counters per class: those not yet past
// the ordering point, and those not yet globally performed.
module mbo_barrier #(
	parameter int CNT_W = mbo_pkg::MBO_CNT_W // Outstanding counter width.
) (
	input wire logic i_clk, // Core clock.
	input wire logic i_nrst, // Asynchronous reset, active low.
	input wire logic i_insn_valid, // Instruction word valid at issue.
	input wire logic [31:0] i_insn, // Instruction at issue.
	output logic o_insn_stall, // Barrier instruction not yet retired.
	input wire logic i_acc_valid, // Memory access wants to issue.
	input wire logic [1:0] i_acc_kind, // Load, store, cache op, prefetch.
	input wire logic [1:0] i_acc_mtype, // Memory access type.
	output logic o_acc_hold, // Access issue held this cycle.
	input wire logic i_ord_ld, // A load passed the ordering point.
	input wire logic i_ord_st, // A store passed the ordering point.
	input wire logic i_done_ld, // A load wrote its destination register.
	input wire logic i_done_st, // A store became globally visible.
	output logic o_ext_order, // External requests must stay in order.
	output logic o_busy // Barrier in progress.
);
	import mbo_pkg::*;

	mbo_state_type state; // Controller state.
	logic dec_bar, dec_old_ld, dec_old_st, dec_y_ld, dec_y_st, dec_cmp;
	logic old_ld, old_st, y_ld, y_st, cmp; // Latched barrier masks.
	logic [CNT_W-1:0] ord_ld_cnt, ord_st_cnt; // Before ordering point.
	logic [CNT_W-1:0] gp_ld_cnt, gp_st_cnt; // Not yet globally performed.
	logic acc_covered, acc_is_ld, issue, met, next_hold, hold;

	mbo_decode u_dec (
		.i_insn(i_insn),
		.o_is_barrier(dec_bar),
		.o_older_ld(dec_old_ld),
		.o_older_st(dec_old_st),
		.o_young_ld(dec_y_ld),
		.o_young_st(dec_y_st),
		.o_complete(dec_cmp)
	);

	// Only uncached and coherent accesses are counted; cache ops and
	// prefetches are treated as loads when counted.
	always_comb begin
		acc_covered = (i_acc_mtype == MBO_MT_UNCACHED)
			|| (i_acc_mtype == MBO_MT_COHERENT);
		acc_is_ld = (i_acc_kind != MBO_K_STORE);
	end

	// Condition is met once every selected older class has drained: to the
	// ordering point only, or to global performance for completion.
	always_comb begin
		met = 1'b1;
		if (old_ld && ord_ld_cnt != '0) begin
			met = 1'b0;
		end
		if (old_st && ord_st_cnt != '0) begin
			met = 1'b0;
		end
		if (cmp && (gp_ld_cnt != '0 || gp_st_cnt != '0)) begin
			met = 1'b0;
		end
	end

	// Every younger access waits while a barrier is in progress; fetch is never held.
	always_comb begin
		next_hold = 1'b0;
		if (state != MBO_IDLE || (i_insn_valid && dec_bar)) begin
			next_hold = 1'b1;
		end
		issue = i_acc_valid && !hold;
	end

	// Hold is registered; a held access is younger, so blocking uncovered
	// classes too keeps program order simple at a cycle's cost.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			hold <= 1'b0;
		end else begin
			hold <= next_hold;
		end
	end

	// Barrier sequencing.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= MBO_IDLE;
			old_ld <= 1'b0;
			old_st <= 1'b0;
			y_ld <= 1'b0;
			y_st <= 1'b0;
			cmp <= 1'b0;
		end else begin
			unique case (state)
				MBO_IDLE: begin
					if (i_insn_valid && dec_bar) begin
						old_ld <= dec_old_ld;
						old_st <= dec_old_st;
						y_ld <= dec_y_ld;
						y_st <= dec_y_st;
						cmp <= dec_cmp;
						state <= MBO_DRAIN;
					end
				end
				MBO_DRAIN: begin
					if (met) begin
						state <= MBO_RELEASE;
					end
				end
				MBO_RELEASE: begin
					state <= MBO_IDLE;
				end
			endcase
		end
	end

	// Outstanding counters; loads are done at writeback, stores when
	// visible everywhere.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ord_ld_cnt <= MBO_CNT_RST;
			ord_st_cnt <= MBO_CNT_RST;
			gp_ld_cnt <= MBO_CNT_RST;
			gp_st_cnt <= MBO_CNT_RST;
		end else begin
			ord_ld_cnt <= ord_ld_cnt
				+ CNT_W'(issue && acc_covered && acc_is_ld) - CNT_W'(i_ord_ld);
			ord_st_cnt <= ord_st_cnt
				+ CNT_W'(issue && acc_covered && !acc_is_ld) - CNT_W'(i_ord_st);
			gp_ld_cnt <= gp_ld_cnt
				+ CNT_W'(issue && acc_covered && acc_is_ld)
				- CNT_W'(i_done_ld);
			gp_st_cnt <= gp_st_cnt
				+ CNT_W'(issue && acc_covered && !acc_is_ld)
				- CNT_W'(i_done_st);
		end
	end

	// Registered outputs.
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_acc_hold <= 1'b0;
			o_insn_stall <= 1'b0;
			o_ext_order <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_acc_hold <= next_hold;
			o_insn_stall <= (state == MBO_DRAIN) && !met;
			// At the taking edge the latched mask is stale, so use the decode.
			if (state == MBO_IDLE) begin
				o_ext_order <= next_hold && !(i_insn_valid && dec_bar && dec_cmp);
			end else begin
				o_ext_order <= next_hold && !cmp;
			end
			o_busy <= next_hold;
		end
	end
endmodule // mbo_barrier

// >>> mbo_barrier_chk.sv
// Port-level checker for the barrier controller.
module mbo_barrier_chk (
	input wire logic i_clk, // Core clock.
	input wire logic i_nrst, // Reset, active low.
	input wire logic i_insn_valid, // Issue valid.
	input wire logic [31:0] i_insn, // Issue word.
	input wire logic o_insn_stall, // Barrier stall.
	input wire logic o_acc_hold, // Access hold.
	input wire logic o_ext_order, // Ordering mode.
	input wire logic o_busy // Barrier busy.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Fixed opcode bits with the spare field zero.
	wire logic is_bar = i_insn[31:21] == 11'h000 && i_insn[15:0] == 16'h6B7C;
	// Types that only order, with no completion wait.
	wire logic ord = i_insn[20:16] inside {5'h04, [5'h10:5'h13]};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// A new barrier is only taken from idle.
	sequence s_take;
		i_insn_valid && is_bar && !o_busy;
	endsequence
	a_take_busy: assert property (s_take |=> o_busy)
		else $error("barrier not taken");
	a_take_mode: assert property (s_take |=> o_ext_order == $past(ord))
		else $error("barrier mode wrong");
	a_hold_busy: assert property (o_busy |-> o_acc_hold)
		else $error("access not held");
	a_idle_free: assert property (!o_busy |-> !o_acc_hold)
		else $error("hold while idle");
	a_ext_busy: assert property (o_ext_order |-> o_busy)
		else $error("order flag outside barrier");
	a_stall_busy: assert property (o_insn_stall |-> o_busy)
		else $error("stall outside barrier");
	a_busy_bound: assert property ($rose(o_busy) |-> ##[1:300] !o_busy)
		else $error("barrier never ends");
	a_mode_steady: assert property (o_busy [*2] |-> !$rose(o_ext_order))
		else $error("mode changed mid barrier");
endmodule // mbo_barrier_chk
bind mbo_barrier mbo_barrier_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
	.i_insn_valid(i_insn_valid), .i_insn(i_insn), .o_insn_stall(o_insn_stall),
	.o_acc_hold(o_acc_hold), .o_ext_order(o_ext_order), .o_busy(o_busy));

// >>> mbo_decode.sv
// Instruction decoder for the barrier: produces the class masks.
module mbo_decode (
	input wire logic [31:0] i_insn, // Instruction word.
	output logic o_is_barrier, // Instruction is a barrier.
	output logic o_older_ld, // Older loads must reach ordering point.
	output logic o_older_st, // Older stores must reach ordering point.
	output logic o_young_ld, // Younger loads are held.
	output logic o_young_st, // Younger stores are held.
	output logic o_complete // Older accesses must be globally performed.
);
	import mbo_pkg::*;
	logic [4:0] btype;

	// Field match; the spare five-bit field must be zero.
	always_comb begin
		btype = i_insn[MBO_TYPE_LSB +: 5];
		o_is_barrier = (i_insn[MBO_MAJ_LSB +: 6] == MBO_MAJOR_OPCODE_GROUP)
			&& (i_insn[MBO_ZERO_LSB +: 5] == 5'h00)
			&& (i_insn[MBO_MINOR_LSB +: 10] == MBO_MINOR_BARRIER)
			&& (i_insn[5:0] == MBO_EXTENDED_FUNCTION_GROUP);
	end

	// Per-type masks; every other code falls to the completion barrier.
	always_comb begin
		o_older_ld = 1'b1;
		o_older_st = 1'b1;
		o_young_ld = 1'b1;
		o_young_st = 1'b1;
		o_complete = 1'b0;
		case (btype)
			MBO_T_WRITE_BARRIER: begin
				o_older_ld = 1'b0;
				o_young_ld = 1'b0;
			end
			MBO_T_READ_BARRIER: begin
				o_older_st = 1'b0;
				o_young_st = 1'b0;
			end
			MBO_T_ACQUIRE: begin
				o_older_st = 1'b0;
			end
			MBO_T_RELEASE: begin
				o_young_ld = 1'b0;
			end
			MBO_T_FULL_ORDERING_BARRIER: begin
			end
			default: begin
				o_complete = 1'b1;
			end
		endcase
	end
endmodule // mbo_decode

// >>> mbo_lsu_model.sv
// Load/store datapath: an access passes the ordering point, then completes.
module mbo_lsu_model (
	input wire logic i_clk, // Core clock.
	input wire logic i_nrst, // Reset, active low.
	input wire logic i_issue, // Covered access issued.
	input wire logic i_st, // Issued access is a store.
	input wire logic i_slow, // Answer slowly.
	output logic [1:0] o_ord, // Passed ordering point, store high.
	output logic [1:0] o_done // Completed, store high.
);
	timeunit 1ns;
	timeprecision 1ps;
	int po[2]; // Waiting for the ordering point.
	int pd[2]; // Waiting for completion.
	int cyc; // Pacing for slow answers.
	// Completion always follows the ordering point, never precedes it.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			po = '{0, 0};
			pd = '{0, 0};
			o_ord <= 2'h0;
			o_done <= 2'h0;
		end else begin
			cyc++;
			for (int c = 0; c < 2; c++) begin
				o_ord[c] <= po[c] > 0 && (!i_slow || cyc % 4 == 0);
				o_done[c] <= pd[c] > 0 && (!i_slow || cyc % 8 == 0);
				if (pd[c] > 0 && (!i_slow || cyc % 8 == 0)) pd[c]--;
				if (po[c] > 0 && (!i_slow || cyc % 4 == 0)) begin
					po[c]--;
					pd[c]++;
				end
			end
			if (i_issue) po[i_st]++;
		end
	end
endmodule // mbo_lsu_model

// >>> mbo_pkg.sv
// Notes on behaviour
// - Decode barrier opcode; take five-bit type field.
// - Type zero is full completion barrier.
// - Older covered accesses globally performed before younger.
// - Load done at writeback; store when visible.
// - Only uncached or coherent accesses are constrained; the code holds every access during a barrier.
// - Instruction fetches are never held by barriers.
// - Undefined nonzero types act as type zero.
// - Ordering barrier: older reach ordering point first.
// - External requests globally performed in program order.
// - Ordering barrier skips waiting for completion.
// - Cache ops and prefetches count as accesses.
// - Type 4 orders stores; 0x13 orders loads.
// - Acquire and release order loads and stores.
// - Type 0x10 full ordering without completion.
package mbo_pkg;
	// Instruction field layout.
	localparam int MBO_MAJ_LSB = 26;
	localparam int MBO_ZERO_LSB = 21;
	localparam int MBO_TYPE_LSB = 16;
	localparam int MBO_MINOR_LSB = 6;
	localparam logic [5:0] MBO_MAJOR_OPCODE_GROUP = 6'h00;
	localparam logic [9:0] MBO_MINOR_BARRIER = 10'h1AD;
	localparam logic [5:0] MBO_EXTENDED_FUNCTION_GROUP = 6'h3C;
	// Barrier type codes.
	localparam logic [4:0] MBO_T_COMPLETION = 5'h00;
	localparam logic [4:0] MBO_T_WRITE_BARRIER = 5'h04;
	localparam logic [4:0] MBO_T_FULL_ORDERING_BARRIER = 5'h10;
	localparam logic [4:0] MBO_T_ACQUIRE = 5'h11;
	localparam logic [4:0] MBO_T_RELEASE = 5'h12;
	localparam logic [4:0] MBO_T_READ_BARRIER = 5'h13;
	// Access memory types.
	localparam logic [1:0] MBO_MT_UNCACHED = 2'h0;
	localparam logic [1:0] MBO_MT_COHERENT = 2'h1;
	// Access kinds.
	localparam logic [1:0] MBO_K_LOAD = 2'h0;
	localparam logic [1:0] MBO_K_STORE = 2'h1;
	localparam logic [1:0] MBO_K_CACHE_OP = 2'h2;
	localparam logic [1:0] MBO_K_PREFETCH = 2'h3;
	// Outstanding counter width and reset value.
	localparam int MBO_CNT_W = 6;
	localparam logic [5:0] MBO_CNT_RST = 6'h00;
	// Barrier controller states, one-hot.
	typedef enum logic [2:0] {
		MBO_IDLE = 3'b001,
		MBO_DRAIN = 3'b010,
		MBO_RELEASE = 3'b100
	} mbo_state_type;
endpackage

// >>> memory_barrier_ordering_tb_top.sv
module memory_barrier_ordering_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 0, i_nrst, i_insn_valid, i_acc_valid, slow;
	logic [31:0] i_insn;
	logic [1:0] i_acc_kind, i_acc_mtype, ord, done;
	logic o_acc_hold, o_busy, o_ext_order;
	int n_fail = 0, num_checks = 0, n, oc[2] = '{0, 0}, dc[2] = '{0, 0};
	// Only uncached and coherent accesses are counted by the datapath.
	wire logic issue = i_acc_valid && !o_acc_hold && i_acc_mtype < 2'h2;
	always #20 i_clk = ~i_clk;
	mbo_barrier mbo_barrier_inst (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_insn_valid(i_insn_valid), .i_insn(i_insn), .o_insn_stall(),
		.i_acc_valid(i_acc_valid), .i_acc_kind(i_acc_kind),
		.i_acc_mtype(i_acc_mtype), .o_acc_hold(o_acc_hold),
		.i_ord_ld(ord[0]), .i_ord_st(ord[1]), .i_done_ld(done[0]),
		.i_done_st(done[1]), .o_ext_order(o_ext_order), .o_busy(o_busy));
	mbo_lsu_model mbo_lsu_model_inst (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_issue(issue), .i_st(i_acc_kind == 2'h1), .i_slow(slow),
		.o_ord(ord), .o_done(done));
	// Older accesses still short of the ordering point or of completion.
	always @(posedge i_clk) begin
		if (i_nrst && issue) oc[i_acc_kind == 2'h1]++;
		for (int c = 0; c < 2 && i_nrst; c++) begin
			oc[c] -= ord[c];
			dc[c] += ord[c] - done[c];
		end
	end
	// Work a barrier type must have finished before the barrier ends.
	function automatic int left(int t);
		case (t)
			4: return oc[1];
			16, 18: return oc[0] + oc[1];
			17, 19: return oc[0];
			default: return oc[0] + oc[1] + dc[0] + dc[1];
		endcase
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Cuts a hang short well beyond the expected run length.
	initial begin
		#800000;
		n_fail++;
		end_of_test;
	end
	// Every barrier type, each after a random burst of older accesses.
	initial begin
		{i_nrst, i_insn_valid, i_acc_valid, slow} = 4'h0;
		{i_insn, i_acc_kind, i_acc_mtype} = '0;
		void'($urandom(32'h36E9B1F8));
		repeat (3) @(negedge i_clk);
		i_nrst = 1;
		for (int t = 0; t < 32; t++) begin
			slow = $urandom;
			repeat ($urandom_range(1, 6)) begin
				@(negedge i_clk);
				i_acc_valid = 1;
				i_acc_kind = $urandom;
				i_acc_mtype = $urandom_range(0, 3);
			end
			@(negedge i_clk);
			i_acc_valid = 0;
			i_insn_valid = 1;
			i_insn = {11'h000, 5'(t), 16'h6B7C};
			@(negedge i_clk);
			i_insn_valid = 0;
			i_acc_valid = 1;
			chk(o_busy, 1);
			chk(o_ext_order, t inside {4, [16:19]});
			for (n = 0; o_busy !== 1'b0 && n < 400; n++) @(negedge i_clk);
			chk(o_busy, 0);
			chk(left(t), 0);
			i_acc_valid = 0;
		end
		end_of_test;
	end
endmodule // memory_barrier_ordering_tb_top
